// ==== hw/command_status_registers.sv ====
// serial command frame decoder with status and special operation registers
`include "cmd_status_cfg.svh"
`default_nettype none
module command_status_registers #(
  parameter logic [7:0] FW_MAJOR = 8'h00,  // arbitrary value
  parameter logic [7:0] FW_MINOR = 8'h00,  // arbitrary value
  parameter logic [7:0] FW_INCREMENTAL = 8'h00,  // arbitrary value
  parameter logic [7:0] FW_SUFFIX = 8'h00,  // arbitrary value
  parameter logic [7:0] REFRESH_WRITES = `REFRESH_WRITES_DEFAULT
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  output logic RX_READY,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  input wire logic TRANSMITTER_ACTIVE_LINE,
  input wire logic RECEIVER_ACTIVE_LINE,
  input wire logic INBOUND_NEAR_FULL_LINE,
  input wire logic RF_TRANSFER_ACTIVE_LINE,
  input wire logic UART_QUEUE_DRAINED_LINE,
  input wire logic EXPLICIT_TRANSMIT_FRAMING,
  input wire logic EXPLICIT_RECEIVE_FRAMING,
  input wire logic FAULT_EVENT,
  input wire logic [7:0] FAULT_EVENT_CODE,
  input wire logic NV_WRITE_DONE,
  input wire logic OUTBOUND_BYTE,
  input wire logic FETCH_DONE,
  output logic FAULT_PENDING_LINE,
  output logic OP_STROBE,
  output logic [7:0] OP_CODE,
  output logic [7:0] OP_ARG,
  output logic SEND_FLUSH,
  output logic PACKET_CLOSE,
  output logic DISCARD_PAYLOAD,
  output logic FACTORY_RESTORE,
  output logic REFRESH_CYCLE,
  output logic [15:0] REFRESH_CYCLE_COUNT
);

  cmd_status_pkg::csr_state_t cur;
  cmd_status_pkg::csr_state_t nxt;

  logic rx_fire;
  logic [7:0] plain;
  logic [2:0] nb;
  logic [3:0][7:0] bd;
  logic exec;
  logic is_read;
  logic ro_write;
  logic is_fetch;
  logic fetch_ok;
  logic [7:0] op;
  logic [7:0] raddr;
  logic [7:0] line_snapshot;
  logic resp_ready;

  byte_stream_if #(.W(8)) resp_in ();
  byte_stream_if #(.W(8)) resp_out ();

  // ======================================================================
  // response buffer, stalls the parser when the host stops draining
  assign resp_in.data = cur.push_data;
  assign resp_in.valid = cur.push_valid;
  assign resp_ready = resp_in.ready;
  assign TX_DATA = resp_out.data;
  assign TX_VALID = resp_out.valid;
  assign resp_out.ready = TX_READY;

  byte_fifo #(.W(8), .DEPTH(`RESP_FIFO_DEPTH)) reply_buf (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .ce(CLK_EN),
    .fill(resp_in),
    .drain(resp_out)
  );

  // ======================================================================
  // next state
  always_comb begin
    nxt = cur;
    nxt.op_strobe = 1'b0;
    nxt.send_flush = 1'b0;
    nxt.packet_close = 1'b0;
    nxt.discard_payload = 1'b0;
    nxt.factory_restore = 1'b0;
    nxt.refresh = 1'b0;
    rx_fire = RX_VALID && cur.rx_ready;
    plain = cur.esc ? (RX_DATA | `FRAME_ESC_BIT) : RX_DATA;
    nb = cur.nbytes;
    bd = cur.body;
    exec = 1'b0;
    is_read = 1'b0;
    ro_write = 1'b0;
    is_fetch = 1'b0;
    fetch_ok = 1'b0;
    op = cur.body[1];
    raddr = '0;
    // reserved bits are forced low here, whatever the lines do
    line_snapshot = {`RESERVED_BITS, UART_QUEUE_DRAINED_LINE,
                     RF_TRANSFER_ACTIVE_LINE, INBOUND_NEAR_FULL_LINE,
                     RECEIVER_ACTIVE_LINE, TRANSMITTER_ACTIVE_LINE,
                     cur.exc_pending};

    // fetch completion clears busy, but a fetch frame ending in the same cycle is judged on the old busy flag
    if (FETCH_DONE) begin
      nxt.fetch_busy = 1'b0;
    end

    // frame parser: header resyncs from any receive phase
    if (rx_fire && RX_DATA == `FRAME_HEADER) begin
      nxt.phase = cmd_status_pkg::PH_SIZE;
    end else if (rx_fire) begin
      unique case (cur.phase)
        cmd_status_pkg::PH_SIZE: begin
          nxt.remain = RX_DATA;
          nxt.esc = 1'b0;
          nxt.nbytes = '0;
          nxt.phase = (RX_DATA == 8'h00) ? cmd_status_pkg::PH_HDR
                                         : cmd_status_pkg::PH_BODY;
        end
        cmd_status_pkg::PH_BODY: begin
          nxt.remain = cur.remain - 8'd1;
          if (!cur.esc && RX_DATA == `FRAME_ESCAPE) begin
            nxt.esc = 1'b1;
          end else begin
            nxt.esc = 1'b0;
            // bytes past the fourth are not kept; the byte count holds at four
            if (cur.nbytes != `BODY_KEEP) begin
              bd[cur.nbytes[1:0]] = plain;
              nb = cur.nbytes + 3'd1;
            end
          end
          nxt.body = bd;
          nxt.nbytes = nb;
          exec = (cur.remain == 8'd1);
          op = bd[1];
        end
        default: begin
          nxt.phase = cmd_status_pkg::PH_HDR;
        end
      endcase
    end

    // ====================================================================
    // frame execution
    if (exec) begin
      nxt.phase = cmd_status_pkg::PH_RESP;
      nxt.resp_idx = '0;
      nxt.resp = {8'h00, 8'h00, `REPLY_NACK};
      nxt.resp_len = 2'd1;
      // short read: one escaped byte; long read: mark, then escaped address
      is_read = !nxt.esc && ((nb == 3'd2 && bd[0] == `READ_MARK) ||
                (nb == 3'd1 && (bd[0] & `FRAME_ESC_BIT) != 8'h00));
      raddr = (nb == 3'd1) ? (bd[0] & ~`FRAME_ESC_BIT)
                           : (bd[1] | `FRAME_ESC_BIT);
      ro_write = (bd[0] >= `ADDR_FW_MAJOR) && (bd[0] <= `ADDR_LINE_SNAPSHOT);
      is_fetch = (bd[0] == `ADDR_SPECIAL_OP) &&
                 (op == `OP_FETCH_HEADER || op == `OP_FETCH_PAYLOAD ||
                  op == `OP_FETCH_HEADER_PAYLOAD);
      fetch_ok = EXPLICIT_RECEIVE_FRAMING && !cur.fetch_busy;
      if (is_read) begin
        // read answer carries the real address, not the escaped one
        nxt.resp = {8'h00, raddr, `REPLY_ACK};
        nxt.resp_len = 2'd3;
        unique case (raddr)
          `ADDR_FW_MAJOR: nxt.resp[2] = FW_MAJOR;
          `ADDR_FW_MINOR: nxt.resp[2] = FW_MINOR;
          `ADDR_FW_INCR: nxt.resp[2] = FW_INCREMENTAL;
          `ADDR_FW_SUFFIX: nxt.resp[2] = FW_SUFFIX;
          `ADDR_REFRESH_HIGH: nxt.resp[2] = cur.refresh_count[15:8];
          `ADDR_REFRESH_LOW: nxt.resp[2] = cur.refresh_count[7:0];
          `ADDR_LINE_SNAPSHOT: nxt.resp[2] = line_snapshot;
          `ADDR_FAULT_CODE: begin
            nxt.resp[2] = cur.exc_code;
            nxt.exc_pending = 1'b0;
          end
          default: begin
            nxt.resp = {8'h00, 8'h00, `REPLY_NACK};
            nxt.resp_len = 2'd1;
          end
        endcase
      end else if (bd[0] == `ADDR_SPECIAL_OP && nb >= 3'd2) begin
        // write-only port: the value is latched onto OP_CODE, never read back
        nxt.resp[0] = `REPLY_ACK;
        nxt.op_code = op;
        // short frames carry no argument; stale body bytes must not leak
        nxt.op_arg = (nb >= 3'd3) ? bd[2] : 8'h00;
        nxt.op_strobe = 1'b1;
        unique case (op)
          `OP_SEND_PACKET: begin
            if (EXPLICIT_TRANSMIT_FRAMING) begin
              // close only; earlier closed packets keep their place
              nxt.packet_close = 1'b1;
            end else begin
              nxt.send_flush = 1'b1;
            end
            nxt.out_count = '0;
          end
          `OP_FETCH_HEADER, `OP_FETCH_PAYLOAD,
          `OP_FETCH_HEADER_PAYLOAD: begin
            if (!fetch_ok) begin
              nxt.resp[0] = `REPLY_NACK;
              nxt.op_strobe = 1'b0;
            end else begin
              nxt.fetch_busy = 1'b1;
              // header fetched again before its payload: drop it
              nxt.discard_payload = (op == `OP_FETCH_HEADER) &&
                                    cur.header_taken;
              // header goes, payload stays readable
              nxt.header_taken = (op == `OP_FETCH_HEADER);
            end
          end
          `OP_DROP_RECEIVED: begin
            nxt.header_taken = 1'b0;
            nxt.fetch_busy = 1'b0;
          end
          `OP_FLUSH_OUTBOUND: nxt.out_count = '0;
          `OP_FLUSH_INBOUND, `OP_PAIRING_CONTROL, `OP_STORE_KEY,
          `OP_ERASE_KEY, `OP_RESTORE_KEY: nxt.op_strobe = 1'b1;
          `OP_FACTORY_RESTORE: begin
            // both confirmation bytes, in order; bytes after the fourth are not checked
            if (nb == 3'd4 && bd[2] == `CONFIRM_FIRST &&
                bd[3] == `CONFIRM_SECOND) begin
              nxt.factory_restore = 1'b1;
            end else begin
              nxt.resp[0] = `REPLY_NACK;
              nxt.op_strobe = 1'b0;
            end
          end
          default: begin
            nxt.resp[0] = `REPLY_NACK;
            nxt.op_strobe = 1'b0;
          end
        endcase
      end else if (ro_write) begin
        // read-only registers answer a write with a refusal
        nxt.resp[0] = `REPLY_NACK;
      end
      nxt.push_valid = 1'b1;
      nxt.push_data = nxt.resp[0];
    end

    // ====================================================================
    // reply bytes into the buffer, one per accepted handshake
    if (cur.phase == cmd_status_pkg::PH_RESP && cur.push_valid &&
        resp_ready) begin
      nxt.resp_idx = cur.resp_idx + 2'd1;
      if (cur.resp_idx + 2'd1 == cur.resp_len) begin
        nxt.push_valid = 1'b0;
        nxt.phase = cmd_status_pkg::PH_HDR;
      end else begin
        nxt.push_data = cur.resp[cur.resp_idx + 2'd1];
      end
    end
    // parser takes bytes only when no reply is pending
    nxt.rx_ready = (nxt.phase != cmd_status_pkg::PH_RESP);

    // ====================================================================
    // a new fault in the same cycle as the read wins over the read's clear
    if (FAULT_EVENT) begin
      nxt.exc_pending = 1'b1;
      nxt.exc_code = FAULT_EVENT_CODE;
    end

    // stored-memory wear tracking; threshold capped at the default, no lower bound applied
    if (NV_WRITE_DONE) begin
      if (cur.nv_writes + 8'd1 >= REFRESH_WRITES ||
          cur.nv_writes + 8'd1 >= `REFRESH_WRITES_DEFAULT) begin
        nxt.nv_writes = '0;
        nxt.refresh = 1'b1;
        nxt.refresh_count = cur.refresh_count + 16'd1;
      end else begin
        nxt.nv_writes = cur.nv_writes + 8'd1;
      end
    end

    // an open explicit packet is closed by force when it reaches the limit
    if (OUTBOUND_BYTE && EXPLICIT_TRANSMIT_FRAMING) begin
      if (nxt.out_count + 8'd1 == `PACKET_MAX_BYTES) begin
        nxt.out_count = '0;
        nxt.packet_close = 1'b1;
      end else begin
        nxt.out_count = nxt.out_count + 8'd1;
      end
    end
  end

  // ======================================================================
  // state register, frozen while the clock enable is low
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cur <= '0;
    end else if (CLK_EN) begin
      cur <= nxt;
    end
  end

  // ======================================================================
  // outputs, each a field of the state register
  assign RX_READY = cur.rx_ready;
  assign FAULT_PENDING_LINE = cur.exc_pending;
  assign OP_STROBE = cur.op_strobe;
  assign OP_CODE = cur.op_code;
  assign OP_ARG = cur.op_arg;
  assign SEND_FLUSH = cur.send_flush;
  assign PACKET_CLOSE = cur.packet_close;
  assign DISCARD_PAYLOAD = cur.discard_payload;
  assign FACTORY_RESTORE = cur.factory_restore;
  assign REFRESH_CYCLE = cur.refresh;
  assign REFRESH_CYCLE_COUNT = cur.refresh_count;

  // ======================================================================
  // checks
  refresh_count_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    $past(CLK_EN) && cur.refresh |->
      cur.refresh_count == $past(cur.refresh_count) + 16'd1)
    else $error("refresh count did not step with refresh");

  status_reserved_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && exec && is_read && raddr == `ADDR_LINE_SNAPSHOT |=>
      cur.resp[2][7:6] == `RESERVED_BITS && cur.resp_len == 2'd3 &&
      cur.resp[1] == `ADDR_LINE_SNAPSHOT)
    else $error("status read reply malformed");

  ro_refused_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && exec && !is_read && ro_write |=>
      cur.resp[0] == `REPLY_NACK && cur.resp_len == 2'd1 && !cur.op_strobe)
    else $error("write to read-only register accepted");

  fetch_refused_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && exec && is_fetch && !fetch_ok |=>
      cur.resp[0] == `REPLY_NACK && !cur.op_strobe && !cur.discard_payload)
    else $error("fetch accepted while refused");

  payload_discard_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && exec && is_fetch && fetch_ok && op == `OP_FETCH_HEADER &&
    cur.header_taken |=> cur.discard_payload && cur.header_taken)
    else $error("unread payload not discarded");

  restore_confirm_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    $past(CLK_EN) && cur.factory_restore |->
      $past(cur.phase) == cmd_status_pkg::PH_BODY &&
      cur.body[2] == `CONFIRM_FIRST && cur.body[3] == `CONFIRM_SECOND &&
      cur.resp[0] == `REPLY_ACK)
    else $error("factory restore without confirmation");

  fault_clear_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && exec && is_read && raddr == `ADDR_FAULT_CODE |=>
      cur.exc_pending == $past(FAULT_EVENT) && cur.resp[2] == $past(cur.exc_code))
    else $error("fault read did not clear pending");

  send_mode_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    CLK_EN && exec && bd[0] == `ADDR_SPECIAL_OP && op == `OP_SEND_PACKET &&
    nb >= 3'd2 |=>
      cur.send_flush == !$past(EXPLICIT_TRANSMIT_FRAMING) &&
      (cur.packet_close || !$past(EXPLICIT_TRANSMIT_FRAMING)))
    else $error("send did not follow framing mode");

  packet_limit_a: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    cur.out_count < `PACKET_MAX_BYTES)
    else $error("open packet exceeded its limit");

endmodule
`default_nettype wire

// ==== include/cmd_status_cfg.svh ====
// constants of the serial command and status register block
// What this block does
// - four read-only firmware version bytes: major, minor, incremental, suffix
// - sixteen-bit refresh count, high byte at lower address, low byte next
// - refresh after a bounded number of stored writes, counting each refresh
// - status read: escaped address in, acknowledge, real address, value out
// - status bits: fault, transmit, receive, near full, rf active, drained
// - command register is write-only, takes one operation value per frame
// - decode send, fetch, drop, flush, pairing and key operation codes
// - factory restore needs operation 0x20 followed by 0xaa then 0xbb
// - send without explicit framing flushes all waiting outbound data
// - send with explicit framing closes a packet of at most 192 bytes
// - several closed packets may wait, each sent separately in order
// - fetch header delivers and drops the header, payload stays readable
// - repeated fetch header before payload read discards that payload
// - refuse fetches when receive framing is off or a fetch is unfinished
// - reading the fault code clears the pending fault; newer codes overwrite
`ifndef CMD_STATUS_CFG_SVH
`define CMD_STATUS_CFG_SVH

// ======================================================================
// frame bytes
`define FRAME_HEADER 8'hff
`define FRAME_ESCAPE 8'hfe
`define FRAME_ESC_BIT 8'h80
`define READ_MARK 8'hfe
`define REPLY_ACK 8'h06
`define REPLY_NACK 8'h15

// ======================================================================
// register addresses after unescaping
`define ADDR_FW_MAJOR 8'hc0
`define ADDR_FW_MINOR 8'hc1
`define ADDR_FW_INCR 8'hc2
`define ADDR_FW_SUFFIX 8'hc3
`define ADDR_REFRESH_HIGH 8'hc4
`define ADDR_REFRESH_LOW 8'hc5
`define ADDR_LINE_SNAPSHOT 8'hc6
`define ADDR_SPECIAL_OP 8'hc7
`define ADDR_FAULT_CODE 8'h79

// ======================================================================
// operation codes
`define OP_SEND_PACKET 8'h01
`define OP_FETCH_HEADER 8'h02
`define OP_FETCH_PAYLOAD 8'h03
`define OP_FETCH_HEADER_PAYLOAD 8'h04
`define OP_DROP_RECEIVED 8'h05
`define OP_FLUSH_OUTBOUND 8'h06
`define OP_FLUSH_INBOUND 8'h07
`define OP_PAIRING_CONTROL 8'h10
`define OP_STORE_KEY 8'h11
`define OP_ERASE_KEY 8'h12
`define OP_RESTORE_KEY 8'h13
`define OP_FACTORY_RESTORE 8'h20
`define CONFIRM_FIRST 8'haa
`define CONFIRM_SECOND 8'hbb

// ======================================================================
// counts and limits
`define PACKET_MAX_BYTES 8'd192
`define REFRESH_WRITES_DEFAULT 8'd150
`define REFRESH_WRITES_MIN 8'd8
`define BODY_KEEP 3'd4
`define RESP_FIFO_DEPTH 8
`define RESERVED_BITS 2'b00

`endif

// ==== include/cmd_status_pkg.sv ====
// types shared by the command and status block
`default_nettype none
package cmd_status_pkg;

  // ======================================================================
  // frame parser phases
  typedef enum logic [1:0] {
    PH_HDR,
    PH_SIZE,
    PH_BODY,
    PH_RESP
  } phase_t;

  typedef logic [7:0] byte_t;

  // ======================================================================
  // whole state of the register block
  typedef struct packed {
    phase_t phase;
    byte_t remain;
    logic esc;
    logic [2:0] nbytes;
    logic [3:0][7:0] body;
    logic [2:0][7:0] resp;
    logic [1:0] resp_len;
    logic [1:0] resp_idx;
    logic push_valid;
    byte_t push_data;
    logic rx_ready;
    logic exc_pending;
    byte_t exc_code;
    logic header_taken;
    logic fetch_busy;
    byte_t nv_writes;
    logic [15:0] refresh_count;
    byte_t out_count;
    logic op_strobe;
    byte_t op_code;
    byte_t op_arg;
    logic send_flush;
    logic packet_close;
    logic discard_payload;
    logic factory_restore;
    logic refresh;
  } csr_state_t;

endpackage
`default_nettype wire

// ==== include/byte_stream_if.sv ====
// valid and ready stream carrier between the block and its buffer
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ==== hw/byte_fifo.sv ====
// flip-flop fifo with a registered output stage
`default_nettype none
module byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  byte_stream_if.snk fill,
  byte_stream_if.src drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // sized to the count, so a power-of-two depth does not wrap to zero
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] count;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic out_valid;
    logic [W-1:0] out_data;
  } fifo_state_t;

  fifo_state_t cur;
  fifo_state_t nxt;
  logic push;
  logic take;

  // ======================================================================
  // storage and output stage
  // full is taken from the stored count only, so ready never loops back
  assign fill.ready = (cur.count != FULL);
  assign drain.valid = cur.out_valid;
  assign drain.data = cur.out_data;

  always_comb begin
    nxt = cur;
    push = fill.valid && fill.ready;
    take = (!cur.out_valid || drain.ready) && (cur.count != '0);
    if (cur.out_valid && drain.ready) begin
      nxt.out_valid = 1'b0;
    end
    if (take) begin
      nxt.out_valid = 1'b1;
      nxt.out_data = cur.mem[cur.rd];
      nxt.rd = (cur.rd == LAST) ? '0 : cur.rd + 1'b1;
    end
    if (push) begin
      nxt.mem[cur.wr] = fill.data;
      nxt.wr = (cur.wr == LAST) ? '0 : cur.wr + 1'b1;
    end
    nxt.count = cur.count + (AW+1)'(push) - (AW+1)'(take);
  end

  // frozen while the clock enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else if (ce) begin
      cur <= nxt;
    end
  end

endmodule
`default_nettype wire

// ==== bench/host_model.sv ====
// host side model: offers command bytes and takes reply bytes
`default_nettype none
module host_model (
  input wire logic clk,
  output logic [7:0] rxd,
  output logic rxv,
  input wire logic rxr,
  input wire logic [7:0] txd,
  input wire logic txv,
  output logic txr
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // idle: nothing offered, replies held back so the fifo can fill
  initial begin
    rxd = 8'h00;
    rxv = 1'b0;
    txr = 1'b0;
  end
  // offer one byte, hold it until the parser takes it
  task automatic put(input logic [7:0] b);
    int n;
    @(negedge clk);
    rxd = b;
    rxv = 1'b1;
    n = 0;
    // ready is looked at off the edge, where it has settled
    while (rxr !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    rxv = 1'b0;
    rxd = ~b;  // released line never repeats the last byte
  endtask
  // accept one reply byte at the edge where it is valid
  task automatic get(output logic [7:0] b);
    int n;
    @(negedge clk);
    txr = 1'b1;
    n = 0;
    while (txv !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    b = txd;
    @(posedge clk);
    @(negedge clk);
    txr = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== bench/command_status_registers_tb_top.sv ====
// self-checking bench for the command and status register block
`default_nettype none
module command_status_registers_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // version values are arbitrary
  localparam logic [7:0] VER[4] = '{8'h5a, 8'h3c, 8'h0f, 8'ha5};
  localparam logic [7:0] OPS[11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h06, 8'h07, 8'h10, 8'h11, 8'h12, 8'h13};
  logic clk, rst_n, rxv, rxr, txv, txr, tx_frm, rx_frm, fault, nv, ob, fd;
  logic fline, stb, flush, close, disc, rest, refr;
  logic [7:0] rxd, txd, fcode, opc, last_op, arg;
  logic [4:0] lines;
  logic [15:0] rcount, c;
  logic [15:0] cnt[6] = '{default: 16'h0000};
  int errors, num_checks, cycles;
  // ====
  command_status_registers #(.FW_MAJOR(VER[0]), .FW_MINOR(VER[1]),
    .FW_INCREMENTAL(VER[2]), .FW_SUFFIX(VER[3]), .REFRESH_WRITES(8'd8)
  ) command_status_registers_inst (.REF_CLK(clk), .RESETN(rst_n),
    .CLK_EN(1'b1), .RX_DATA(rxd), .RX_VALID(rxv), .RX_READY(rxr),
    .TX_DATA(txd), .TX_VALID(txv), .TX_READY(txr),
    .TRANSMITTER_ACTIVE_LINE(lines[0]), .RECEIVER_ACTIVE_LINE(lines[1]),
    .INBOUND_NEAR_FULL_LINE(lines[2]), .RF_TRANSFER_ACTIVE_LINE(lines[3]),
    .UART_QUEUE_DRAINED_LINE(lines[4]), .EXPLICIT_TRANSMIT_FRAMING(tx_frm),
    .EXPLICIT_RECEIVE_FRAMING(rx_frm), .FAULT_EVENT(fault),
    .FAULT_EVENT_CODE(fcode), .NV_WRITE_DONE(nv), .OUTBOUND_BYTE(ob),
    .FETCH_DONE(fd), .FAULT_PENDING_LINE(fline), .OP_STROBE(stb),
    .OP_CODE(opc), .OP_ARG(arg), .SEND_FLUSH(flush), .PACKET_CLOSE(close),
    .DISCARD_PAYLOAD(disc), .FACTORY_RESTORE(rest), .REFRESH_CYCLE(refr),
    .REFRESH_CYCLE_COUNT(rcount));
  host_model host_model_inst (.clk(clk), .rxd(rxd), .rxv(rxv), .rxr(rxr),
    .txd(txd), .txv(txv), .txr(txr));
  // ====
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count output pulses off the edge; the cycle ceiling cuts a hang short
  always @(negedge clk) begin
    if (stb === 1'b1) last_op = opc;
    cnt[0] += {15'd0, stb === 1'b1};
    cnt[1] += {15'd0, flush === 1'b1};
    cnt[2] += {15'd0, close === 1'b1};
    cnt[3] += {15'd0, disc === 1'b1};
    cnt[4] += {15'd0, rest === 1'b1};
    cnt[5] += {15'd0, refr === 1'b1};
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  // ====
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string w, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", w, e, s);
    end
  endtask
  // send a whole frame, then take and compare every reply byte
  task automatic xfer(input logic [7:0] q[$], input logic [7:0] e[$]);
    logic [7:0] b;
    foreach (q[i]) host_model_inst.put(q[i]);
    foreach (e[i]) begin
      host_model_inst.get(b);
      check("reply", {8'h00, b}, {8'h00, e[i]});
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    if (a[7])
      xfer({8'hff, 8'h03, 8'hfe, 8'hfe, a & 8'h7f}, {8'h06, a, v});
    else
      xfer({8'hff, 8'h02, 8'hfe, a}, {8'h06, a, v});
  endtask
  task automatic op(input logic [7:0] v, input logic [7:0] r);
    logic [15:0] s;
    s = cnt[0];
    xfer({8'hff, 8'h03, 8'hfe, 8'h47, v}, {r});
    check("strobes", cnt[0] - s, 16'(r == 8'h06));
    if (r == 8'h06) check("op", {8'h00, last_op}, {8'h00, v});
    if (r == 8'h06) check("arg", {8'h00, arg}, 16'h0000);
  endtask
  // one-cycle pulses; the settle gap lets registered outputs land
  task automatic pulse(ref logic s, input int n);
    repeat (n) begin
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
    end
    repeat (2) @(negedge clk);
  endtask
  // ====
  // four reads while the host stalls: fifo fills, parser must wait
  task automatic t_version;
    logic [7:0] b;
    for (int i = 0; i < 4; i++)
      foreach (OPS[k]) if (k < 5) host_model_inst.put(
        k == 0 ? 8'hff : k == 1 ? 8'h03 : k < 4 ? 8'hfe : 8'h40 + 8'(i));
    repeat (20) @(negedge clk);
    check("rx ready", {15'd0, rxr}, 16'd0);
    for (int i = 0; i < 12; i++) begin
      host_model_inst.get(b);
      check("ver", b, i % 3 == 0 ? 8'h06 : i % 3 == 1 ? 8'hc0 + 8'(i / 3)
        : VER[i / 3]);
    end
    check("drained", {15'd0, txv}, 16'd0);
    $display("version test done");
  endtask
  task automatic t_status;
    lines = 5'b10110;
    fcode = 8'h41;
    pulse(fault, 1);
    fcode = 8'h42;
    pulse(fault, 1);
    check("fault", {15'd0, fline}, 16'd1);
    rd(8'hc6, {2'b00, lines, 1'b1});
    rd(8'h79, 8'h42);
    check("fault", {15'd0, fline}, 16'd0);
    lines = 5'b01001;
    rd(8'hc6, {2'b00, lines, 1'b0});
    $display("status test done");
  endtask
  task automatic t_ops;
    rx_frm = 1'b1;
    c = cnt[1];
    foreach (OPS[i]) begin
      op(OPS[i], 8'h06);
      if (OPS[i] inside {8'h02, 8'h03, 8'h04}) pulse(fd, 1);
    end
    check("flushes", cnt[1] - c, 16'd1);
    tx_frm = 1'b1;
    c = cnt[2];
    op(8'h01, 8'h06);
    op(8'h01, 8'h06);
    check("closes", cnt[2] - c, 16'd2);
    $display("ops test done");
  endtask
  // refusals: read-only write, write-only read, bad op, fetch refused
  task automatic t_refuse;
    xfer({8'hff, 8'h03, 8'hfe, 8'h40, 8'h55}, {8'h15});
    rd(8'hc0, VER[0]);
    xfer({8'hff, 8'h03, 8'hfe, 8'hfe, 8'h47}, {8'h15});
    op(8'h08, 8'h15);
    rx_frm = 1'b0;
    op(8'h02, 8'h15);
    rx_frm = 1'b1;
    op(8'h03, 8'h06);
    op(8'h04, 8'h15);
    pulse(fd, 1);
    pulse(fault, 1); // header fetch follows the waiting notice
    op(8'h02, 8'h06);
    pulse(fd, 1);
    c = cnt[3];
    op(8'h02, 8'h06);
    check("discards", cnt[3] - c, 16'd1);
    pulse(fd, 1);
    op(8'h03, 8'h06);
    pulse(fd, 1);
    op(8'h02, 8'h06);
    check("discards", cnt[3] - c, 16'd1);
    pulse(fd, 1);
    $display("refuse test done");
  endtask
  task automatic t_count;
    c = cnt[4];
    xfer({8'hff, 8'h05, 8'hfe, 8'h47, 8'h20, 8'hfe, 8'h2a}, {8'h15});
    xfer({8'hff, 8'h07, 8'hfe, 8'h47, 8'h20, 8'hfe, 8'h2a, 8'hfe, 8'h3b},
      {8'h06});
    check("restores", cnt[4] - c, 16'd1);
    check("arg", {8'h00, arg}, 16'h00aa);
    c = cnt[5];
    pulse(nv, 7); // stored writes as one ascending run
    check("refreshes", cnt[5] - c, 16'd0);
    pulse(nv, 9);
    check("refreshes", cnt[5] - c, 16'd2);
    check("count", rcount, 16'd2);
    rd(8'hc4, 8'h00);
    rd(8'hc5, 8'h02);
    c = cnt[2];
    pulse(ob, 191);
    check("closes", cnt[2] - c, 16'd0);
    pulse(ob, 1);
    check("closes", cnt[2] - c, 16'd1);
    $display("count test done");
  endtask
  // ====
  initial begin
    {rst_n, tx_frm, rx_frm, fault, nv, ob, fd} = '0;
    fcode = 8'h00;
    lines = 5'h00;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_version();
    t_status();
    t_ops();
    t_refuse();
    t_count();
    results();
  end
endmodule
`default_nettype wire
